// ### verilog/gpl_cfg.svh
// Overview of operation
// - Output equals input times multiplier over divider product.
// - Multiplier and dividers 1-160; prescaler, external divider 1-16.
// - Three internal outputs and one external output.
// - Locked outputs align to reference rising edge.
// - External output has three modes, multiplication everywhere.
// - Zero-delay mode aligns output, rejects global shift.
// - External feedback mode aligns feedback, rejects global shifts.
// - Normal mode external output may lag reference.
// - One global phase shift; quadrants exact.
// - Other shifts use 0.3 to 1.0 ns steps.
// - Global shift only for integer frequency ratios.
// - Per-output fine delay, 250 ps steps, +-2 ns.
// - Fine delay works for any frequency ratio.
// - Enable high: all outputs drive clocks.
// - Enable low: outputs low, lock lost.
// - Enable returning high forces fresh lock acquisition.
// - Each instance has its own lock indication.
// - Lock high while reference stays within specification.
// - Lock drops when reference leaves specification.
`ifndef GPL_CFG_SVH
`define GPL_CFG_SVH

// Core clock period and the limits of the settings.
`define GPL_CORE_PERIOD_PS 5000
`define GPL_MUL_MAX 8'ha0
`define GPL_PRE_MAX 8'h10

// Reference period window, in ns, and its cycle counts (least rounds up).
`define GPL_REF_MIN_PERIOD_NS 40
`define GPL_REF_MAX_PERIOD_NS 10000
`define GPL_REF_MIN_CYC \
   ((`GPL_REF_MIN_PERIOD_NS * 1000 + `GPL_CORE_PERIOD_PS - 1) / `GPL_CORE_PERIOD_PS)
`define GPL_REF_MAX_CYC ((`GPL_REF_MAX_PERIOD_NS * 1000) / `GPL_CORE_PERIOD_PS)

// Allowed period wobble between two reference edges, in core cycles.
`define GPL_PERIOD_TOL 1
// Matching reference cycles needed before lock is reported.
`define GPL_LOCK_REF_CYCLES 8

// Fine delay: 250 ps per step up to 2000 ps either way.
`define GPL_FINE_STEP_PS 250
`define GPL_FINE_MAX_PS 2000
`define GPL_FINE_MAX_STEPS (`GPL_FINE_MAX_PS / `GPL_FINE_STEP_PS)

// Global time shift step limits in ps and taps per output period.
`define GPL_PHASE_STEP_MIN_PS 300
`define GPL_PHASE_STEP_MAX_PS 1000
`define GPL_PHASE_TAPS 8

`endif

// ### verilog/gpl_pkg.sv
`default_nettype none
package gpl_pkg;

   // Alignment mode of the external clock output.
   typedef enum logic [1:0] {
      GPL_ZERO_DELAY,
      GPL_EXT_FEEDBACK,
      GPL_NORMAL
   } gpl_ext_mode_type;

   // Division settings: multiplier, prescaler and four post dividers.
   typedef struct packed {
      logic [7:0] mul;
      logic [4:0] pre;
      logic [7:0] div_a;
      logic [7:0] div_b;
      logic [7:0] div_c;
      logic [4:0] div_ext;
   } gpl_div_type;

   // Requested shifts: quadrant, global step count, per-output fine codes.
   typedef struct packed {
      logic [1:0] quadrant;
      logic signed [5:0] step;
      logic [3:0][4:0] fine;
   } gpl_shift_type;

   // Codes for the analog delay cells.
   typedef struct packed {
      logic [3:0][4:0] fine;
      logic signed [5:0] step;
      logic [9:0] step_ps;
   } gpl_trim_type;

endpackage
`default_nettype wire

// ### verilog/gpl_out_gen.sv
`timescale 1ns/100ps
`default_nettype none
// One synthesised output: a rate accumulator that toggles the clock.
module gpl_out_gen (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_start,
   input wire logic [31:0] i_limit,
   input wire logic [8:0] i_inc,
   input wire logic [1:0] i_quad,
   output logic o_clk
);

   logic [32:0] acc_ff; // Accumulated phase in limit units.
   logic clk_ff; // Output level.
   logic [32:0] sum; // Phase after this cycle's increment.
   logic wrap; // A half period has elapsed.
   logic [32:0] nxt_acc;

   // The accumulator adds 2m per core cycle and toggles every n*d*P units,
   // so the average rate is exactly fin*m/(n*d) with no division hardware.
   assign sum = acc_ff + {24'h0, i_inc};
   assign wrap = (sum >= {1'b0, i_limit});
   assign nxt_acc = wrap ? sum - {1'b0, i_limit} : sum;

   // Start preloads the quadrant so all outputs begin on the reference edge.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         acc_ff <= 33'h0;
         clk_ff <= 1'b0;
      end else if (!i_run) begin
         acc_ff <= 33'h0;
         clk_ff <= 1'b0;
      end else if (i_start) begin
         acc_ff <= i_quad[0] ? {2'h0, i_limit[31:1]} : 33'h0;
         clk_ff <= i_quad[1];
      end else begin
         acc_ff <= nxt_acc;
         clk_ff <= wrap ? ~clk_ff : clk_ff;
      end
   end

   assign o_clk = clk_ff;

endmodule
`default_nettype wire

// ### verilog/gpl_pll_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpl_cfg.svh"
// Control and sequencing around one clock synthesis loop.
module gpl_pll_ctrl import gpl_pkg::*; #(
   parameter int LOCK_CNT = `GPL_LOCK_REF_CYCLES,
   parameter int PW = 16
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_shared_pll_enable_pin,
   input wire logic i_ref_clk_pin,
   input wire logic i_fb_clk_pin,
   input wire gpl_div_type i_div,
   input wire gpl_shift_type i_shift,
   input wire gpl_ext_mode_type i_ext_mode,
   input wire logic i_ext_from_b,
   output logic o_core_clk_out_a,
   output logic o_core_clk_out_b,
   output logic o_core_clk_out_c,
   output logic o_ext_clk_out,
   output logic o_lock,
   output gpl_trim_type o_trim,
   output logic o_shift_rejected
);

   // Lock sequencer states.
   typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_LOCKED} gpl_state_type;

   // Forces a divider setting into 1..max.
   function automatic logic [7:0] clamp_div(input logic [7:0] v, input logic [7:0] mx);
      if (v == 8'h0) begin
         return 8'h1;
      end
      return (v > mx) ? mx : v;
   endfunction

   // Fine delay codes beyond the 2 ns span are held at the end stop.
   function automatic logic [4:0] clamp_fine(input logic [4:0] v);
      logic signed [4:0] s;
      s = $signed(v);
      if (s > 5'sd8) begin
         return 5'h08;
      end
      if (s < -5'sd8) begin
         return 5'h18;
      end
      return v;
   endfunction

   // True when fout/fin or fin/fout is an integer.
   function automatic logic ratio_int(input logic [7:0] m, input logic [7:0] n,
                                      input logic [7:0] d);
      logic [15:0] nd;
      nd = 16'(n) * 16'(d);
      return ((16'(m) % nd) == 16'h0) || ((nd % 16'(m)) == 16'h0);
   endfunction

   // Accumulator limit n*d*P for one output.
   function automatic logic [31:0] gen_limit(input logic [PW-1:0] p, input logic [7:0] n,
                                             input logic [7:0] d);
      return 32'(p) * 32'(n) * 32'(d);
   endfunction

   // Pin synchronisers; logic reads the second stage, and the third for edge detection on ref and fb.
   logic en_s1_ff, en_s2_ff;
   logic ref_s1_ff, ref_s2_ff, ref_s3_ff;
   logic fb_s1_ff, fb_s2_ff, fb_s3_ff;

   // Two flip-flops on every pin before any logic looks at it.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         {en_s1_ff, en_s2_ff} <= 2'h0;
         {ref_s1_ff, ref_s2_ff, ref_s3_ff} <= 3'h0;
         {fb_s1_ff, fb_s2_ff, fb_s3_ff} <= 3'h0;
      end else begin
         en_s1_ff <= i_shared_pll_enable_pin;
         en_s2_ff <= en_s1_ff;
         ref_s1_ff <= i_ref_clk_pin;
         ref_s2_ff <= ref_s1_ff;
         ref_s3_ff <= ref_s2_ff;
         fb_s1_ff <= i_fb_clk_pin;
         fb_s2_ff <= fb_s1_ff;
         fb_s3_ff <= fb_s2_ff;
      end
   end

   // Rising edges of the synchronised reference and feedback pins.
   wire ref_rise = ref_s2_ff & ~ref_s3_ff;
   wire fb_rise = fb_s2_ff & ~fb_s3_ff;

   // Settings latched while disabled.
   gpl_div_type div_ff;
   gpl_shift_type shift_ff;
   gpl_ext_mode_type mode_ff;
   logic extb_ff;

   // Clamped settings as they will be latched.
   wire gpl_div_type div_cl;
   assign div_cl.mul = clamp_div(i_div.mul, `GPL_MUL_MAX);
   assign div_cl.pre = 5'(clamp_div({3'h0, i_div.pre}, `GPL_PRE_MAX));
   assign div_cl.div_a = clamp_div(i_div.div_a, `GPL_MUL_MAX);
   assign div_cl.div_b = clamp_div(i_div.div_b, `GPL_MUL_MAX);
   assign div_cl.div_c = clamp_div(i_div.div_c, `GPL_MUL_MAX);
   assign div_cl.div_ext = 5'(clamp_div({3'h0, i_div.div_ext}, `GPL_PRE_MAX));

   // Sequencer registers.
   gpl_state_type state_ff, nxt_state;
   logic [PW-1:0] cnt_ff; // Core cycles since the last reference edge.
   logic [PW-1:0] period_ff; // Last measured reference period.
   logic have_edge_ff; // A first reference edge has been seen.
   logic have_period_ff; // A period is known, so outputs can run.
   logic [7:0] match_ff; // Consecutive matching reference cycles.
   logic fb_seen_ff; // Feedback edge since the last reference edge.
   logic start_ff; // Restarts the generators on a reference edge.

   // Checks made on each reference edge.
   wire en_on = en_s2_ff;
   wire in_spec = (cnt_ff >= PW'(`GPL_REF_MIN_CYC)) && (cnt_ff <= PW'(`GPL_REF_MAX_CYC));
   wire timeout = (cnt_ff > PW'(`GPL_REF_MAX_CYC));
   wire [PW-1:0] diff = (cnt_ff > period_ff) ? cnt_ff - period_ff : period_ff - cnt_ff;
   wire fb_ok = (mode_ff != GPL_EXT_FEEDBACK) || fb_seen_ff || fb_rise;
   wire match = have_period_ff && in_spec && (diff <= PW'(`GPL_PERIOD_TOL)) && fb_ok;
   wire lock_hit = ref_rise && match && (match_ff == 8'(LOCK_CNT - 1));
   wire lose = (ref_rise && !match) || timeout;

   // Next sequencer state; a dropped enable always wins.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (en_on) begin
               nxt_state = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (!en_on) begin
               nxt_state = ST_OFF;
            end else if (lock_hit) begin
               nxt_state = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (!en_on) begin
               nxt_state = ST_OFF;
            end else if (lose) begin
               nxt_state = ST_ACQ;
            end
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
   end

   // State, period measurement and match counting.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= ST_OFF;
         cnt_ff <= '0;
         period_ff <= '0;
         have_edge_ff <= 1'b0;
         have_period_ff <= 1'b0;
         match_ff <= 8'h0;
         fb_seen_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state == ST_OFF) begin
            cnt_ff <= '0;
            have_edge_ff <= 1'b0;
            have_period_ff <= 1'b0;
            match_ff <= 8'h0;
            fb_seen_ff <= 1'b0;
         end else if (ref_rise) begin
            cnt_ff <= PW'(1);
            period_ff <= cnt_ff;
            have_edge_ff <= 1'b1;
            have_period_ff <= have_edge_ff && in_spec;
            match_ff <= match ? match_ff + 8'h1 : 8'h0;
            fb_seen_ff <= 1'b0;
         end else begin
            cnt_ff <= timeout ? cnt_ff : cnt_ff + PW'(1);
            match_ff <= timeout ? 8'h0 : match_ff;
            have_period_ff <= have_period_ff && !timeout;
            fb_seen_ff <= fb_seen_ff | fb_rise;
         end
      end
   end

   // Settings follow the inputs only while disabled; later edits wait for
   // the next enable, so a running loop never sees a torn setting.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         div_ff <= '{mul: 8'h1, pre: 5'h1, div_a: 8'h1, div_b: 8'h1, div_c: 8'h1,
                     div_ext: 5'h1};
         shift_ff <= '0;
         mode_ff <= GPL_NORMAL;
         extb_ff <= 1'b0;
      end else if (state_ff == ST_OFF) begin
         div_ff <= div_cl;
         shift_ff <= i_shift;
         mode_ff <= i_ext_mode;
         extb_ff <= i_ext_from_b;
      end
   end

   // Shift legality: zero delay and feedback modes take no global shift, and a
   // global shift needs an integer ratio on every output in use.
   wire [7:0] pre8 = {3'h0, div_ff.pre};
   wire [7:0] dext = extb_ff ? div_ff.div_b : {3'h0, div_ff.div_ext};
   wire all_int = ratio_int(div_ff.mul, pre8, div_ff.div_a) &&
                  ratio_int(div_ff.mul, pre8, div_ff.div_b) &&
                  ratio_int(div_ff.mul, pre8, div_ff.div_c) &&
                  ratio_int(div_ff.mul, pre8, dext);
   wire want_shift = (shift_ff.quadrant != 2'h0) || (shift_ff.step != 6'sd0);
   wire reject = want_shift && ((mode_ff != GPL_NORMAL) || !all_int);
   wire [1:0] quad = reject ? 2'h0 : shift_ff.quadrant;

   // Global step size scales with the reference period and inversely with the multiplier.
   wire [31:0] ref_ps = 32'(period_ff) * 32'(`GPL_CORE_PERIOD_PS);
   wire [31:0] raw_step = ref_ps / (32'(div_ff.mul) * 32'(`GPL_PHASE_TAPS));
   wire [9:0] step_ps = (raw_step < 32'(`GPL_PHASE_STEP_MIN_PS)) ? 10'(`GPL_PHASE_STEP_MIN_PS) :
                        (raw_step > 32'(`GPL_PHASE_STEP_MAX_PS)) ? 10'(`GPL_PHASE_STEP_MAX_PS) :
                        raw_step[9:0];

   // Generators run from the first known period and are restarted on the
   // reference edge that completes lock, so every output aligns to it.
   wire run = (state_ff != ST_OFF) && have_period_ff;
   wire [3:0] gen_clk;
   wire [3:0][7:0] gen_div;
   assign gen_div[0] = div_ff.div_a;
   assign gen_div[1] = div_ff.div_b;
   assign gen_div[2] = div_ff.div_c;
   assign gen_div[3] = dext;

   // Registered start pulse one cycle after the locking reference edge.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= lock_hit && (state_ff == ST_ACQ);
      end
   end

   // Four outputs: three internal, one external.
   for (genvar g = 0; g < 4; g++) begin : g_out
      gpl_out_gen u_gen (
         .i_core_clk(i_core_clk),
         .i_rst(i_rst),
         .i_run(run),
         .i_start(start_ff),
         .i_limit(gen_limit(period_ff, pre8, gen_div[g])),
         .i_inc({div_ff.mul, 1'b0}),
         .i_quad(quad),
         .o_clk(gen_clk[g])
      );
   end

   // Output registers; internal and zero-delay paths share one stage, while
   // normal mode adds a stage so the board output lags the reference.
   logic [3:0] clk_ff;
   logic ext_ff; // Board clock output register.
   logic lock_ff;
   gpl_trim_type trim_ff;
   logic rej_ff;
   wire [3:0][4:0] fine_cl; // Clamped fine codes, one per output.
   // Normal mode takes the already registered clock, which adds the lag.
   wire ext_src = (mode_ff == GPL_NORMAL) ? clk_ff[3] : gen_clk[3];
   for (genvar f = 0; f < 4; f++) begin : g_fine
      assign fine_cl[f] = clamp_fine(shift_ff.fine[f]);
   end

   // Clock outputs and lock are forced low whenever the enable is low.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_ff <= 4'h0;
         ext_ff <= 1'b0;
         lock_ff <= 1'b0;
         trim_ff <= '0;
         rej_ff <= 1'b0;
      end else begin
         clk_ff <= en_on ? gen_clk : 4'h0;
         ext_ff <= en_on ? ext_src : 1'b0;
         lock_ff <= (nxt_state == ST_LOCKED);
         trim_ff.fine <= fine_cl;
         trim_ff.step <= reject ? 6'sd0 : shift_ff.step;
         trim_ff.step_ps <= step_ps;
         rej_ff <= reject;
      end
   end

   assign o_core_clk_out_a = clk_ff[0];
   assign o_core_clk_out_b = clk_ff[1];
   assign o_core_clk_out_c = clk_ff[2];
   assign o_ext_clk_out = ext_ff;
   assign o_lock = lock_ff;
   assign o_trim = trim_ff;
   assign o_shift_rejected = rej_ff;

   // Enable low for two cycles leaves every clock output and lock low.
   a_disabled_outs_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!en_on ##1 !en_on) |=> (clk_ff == 4'h0) && !ext_ff && !lock_ff)
      else $error("outputs not low while disabled");

   // Lock rises only on a matching edge that completes the count.
   a_lock_rise_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
      $rose(lock_ff) |-> $past(ref_rise) && $past(match_ff) == 8'(LOCK_CNT - 1))
      else $error("lock rose without full count");

   // A mismatching edge while locked drops lock on the next cycle.
   a_mismatch_drops: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (lock_ff && ref_rise && !match) |=> !lock_ff && match_ff == 8'h0)
      else $error("lock kept after mismatch");

   // A stalled reference removes lock.
   a_timeout_drops: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (lock_ff && timeout) |=> !lock_ff)
      else $error("lock kept with reference out of range");

   // No global shift reaches the delay cells in a non-normal mode.
   a_shift_rejected: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (mode_ff != GPL_NORMAL && want_shift) |=> rej_ff && trim_ff.step == 6'sd0)
      else $error("shift passed in aligned mode");

   // The fine code of output a stays within eight steps either way.
   a_fine_range: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ($signed(trim_ff.fine[0]) <= 5'sd8) && ($signed(trim_ff.fine[0]) >= -5'sd8))
      else $error("fine delay code out of range");

   // Latched multiplier and prescaler are never zero nor above their limits.
   a_div_range: assert property (@(posedge i_core_clk) disable iff (i_rst)
      div_ff.mul != 8'h0 && div_ff.mul <= `GPL_MUL_MAX && div_ff.pre != 5'h0 &&
      div_ff.pre <= 5'h10)
      else $error("divider setting out of range");

   // Settings stay frozen while the loop is enabled.
   a_settings_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (state_ff != ST_OFF && $past(state_ff) != ST_OFF) |-> $stable(div_ff))
      else $error("settings changed while enabled");

   // Re-enabling forces acquisition before lock can return.
   a_relock_fresh: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (state_ff == ST_OFF ##1 state_ff != ST_OFF) |-> !lock_ff [*3])
      else $error("lock reported without acquisition");

endmodule
`default_nettype wire

// ### sim/gpl_ref_src.sv
`timescale 1ns/100ps
`default_nettype none
// Board side: a reference oscillator and a board device that returns
// the external clock on the feedback pin after its trace delay.
module gpl_ref_src (
   input wire logic i_run,
   input wire logic [15:0] i_half_ns,
   input wire logic i_ext_clk,
   output logic o_ref_clk,
   output logic o_fb_clk
);
   // The oscillator toggles each half period while running.
   // A stopped oscillator parks low, which looks like a lost reference.
   // The first wait lets the bench set the half period before it is read,
   // and the level is built so that an unset run input cannot make it unknown.
   initial begin
      o_ref_clk = 1'b0;
      #1;
      forever begin
         #(i_half_ns);
         o_ref_clk = (i_run === 1'b1) && (o_ref_clk !== 1'b1);
      end
   end

   // The returned clock lags by a fixed board delay of 2 ns.
   assign #2 o_fb_clk = i_ext_clk;
endmodule
`default_nettype wire

// ### sim/general_purpose_pll_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the loop controller with its board partner.
module general_purpose_pll_control_bench;
   import gpl_pkg::*;
   logic i_core_clk, i_rst, en_pin, from_b, ref_run, ref_clk, fb_clk;
   logic clk_a, clk_b, clk_c, clk_ext, lock, rej;
   logic [15:0] half_ns;
   gpl_div_type div;
   gpl_shift_type shift;
   gpl_ext_mode_type mode;
   gpl_trim_type trim;
   int error_cnt, checks_done, cyc;
   int n[4]; // Rising edges seen on a, b, c and the external output.

   // A short lock count keeps each acquisition to a few reference edges.
   gpl_pll_ctrl #(.LOCK_CNT(3), .PW(16)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_shared_pll_enable_pin(en_pin),
      .i_ref_clk_pin(ref_clk), .i_fb_clk_pin(fb_clk), .i_div(div), .i_shift(shift),
      .i_ext_mode(mode), .i_ext_from_b(from_b), .o_core_clk_out_a(clk_a),
      .o_core_clk_out_b(clk_b), .o_core_clk_out_c(clk_c), .o_ext_clk_out(clk_ext),
      .o_lock(lock), .o_trim(trim), .o_shift_rejected(rej));
   gpl_ref_src board (.i_run(ref_run), .i_half_ns(half_ns), .i_ext_clk(clk_ext),
      .o_ref_clk(ref_clk), .o_fb_clk(fb_clk));

   // The 200 MHz core clock.
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // The hang limit is about two and a half times the length of the planned run.
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         end_sim;
      end
   end

   task automatic end_sim;
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Edge counts are quantised to core cycles, so one edge either way is fine.
   task automatic near(input string what, input int exp, input int got);
      checks_done++;
      if (got < exp - 1 || got > exp + 1) begin
         error_cnt++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Settings are only taken while disabled, so they change in the off time.
   task automatic start(input logic [7:0] m, input logic [4:0] e, input logic [1:0] q,
                        input gpl_ext_mode_type md, input logic sb);
      @(posedge i_core_clk) en_pin <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      div <= '{mul:m, pre:5'h01, div_a:8'h02, div_b:8'h04, div_c:8'h01, div_ext:e};
      shift <= '{quadrant:q, step:6'sh02, fine:{5'h00, 5'h00, 5'h1c, 5'h0c}};
      mode <= md;
      from_b <= sb;
      repeat (4) @(posedge i_core_clk);
      en_pin <= 1'b1;
   endtask

   // Waits, bounded, for the lock level to reach a value; sampled mid-cycle.
   task automatic wait_lock(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && lock !== v; i++) @(negedge i_core_clk);
      chk("lock level", v, lock);
   endtask

   // Counts rising edges of the four outputs over a number of core cycles.
   task automatic count(input int cyc_n);
      logic [3:0] prev, now;
      n = '{0, 0, 0, 0};
      @(negedge i_core_clk);
      prev = {clk_ext, clk_c, clk_b, clk_a};
      repeat (cyc_n) begin
         @(negedge i_core_clk);
         now = {clk_ext, clk_c, clk_b, clk_a};
         for (int k = 0; k < 4; k++) if (now[k] && !prev[k]) n[k]++;
         prev = now;
      end
   endtask

   // Lock needs five edges, so 600 cycles after enable it cannot be up yet.
   task automatic t_lock;
      start(8'h04, 5'h08, 2'h0, GPL_NORMAL, 1'b0);
      repeat (600) @(negedge i_core_clk);
      chk("early lock", 0, lock);
      wait_lock(1'b1, 3000);
   endtask

   // With fref 1 MHz and m 4 the window of 10 us sees 20, 10, 40 and 5 edges.
   task automatic t_freq;
      count(2000);
      near("out a", 20, n[0]);
      near("out b", 10, n[1]);
      near("out c", 40, n[2]);
      near("out ext", 5, n[3]);
      chk("lock kept", 1, lock);
      @(posedge i_core_clk) div.div_a <= 8'h01;
      count(2000);
      near("out a after late change", 20, n[0]);
   endtask

   // The external output follows output b when that source is chosen.
   task automatic t_from_b;
      start(8'h04, 5'h08, 2'h0, GPL_NORMAL, 1'b1);
      wait_lock(1'b1, 3000);
      count(2000);
      near("ext from b", 10, n[3]);
   endtask

   // Disable forces every output low and drops lock; enable must relock.
   task automatic t_off;
      @(posedge i_core_clk) en_pin <= 1'b0;
      repeat (4) @(negedge i_core_clk);
      chk("outputs off", 5'h00, {clk_a, clk_b, clk_c, clk_ext, lock});
      count(300);
      chk("edges off", 0, n[0] + n[1] + n[2] + n[3]);
      @(posedge i_core_clk) en_pin <= 1'b1;
      repeat (600) @(negedge i_core_clk);
      chk("lock before relock", 0, lock);
      wait_lock(1'b1, 3000);
   endtask

   // A changed period must drop lock at once; a stopped one after the timeout.
   task automatic t_ref;
      @(posedge i_core_clk) half_ns <= 16'd300;
      wait_lock(1'b0, 400);
      wait_lock(1'b1, 3000);
      @(posedge i_core_clk) ref_run <= 1'b0;
      wait_lock(1'b0, 2300);
      @(posedge i_core_clk) ref_run <= 1'b1;
      half_ns <= 16'd500;
      wait_lock(1'b1, 3000);
   endtask

   // Each mode with a requested shift; m 3 makes output a a ratio of 1.5.
   task automatic t_shift;
      gpl_ext_mode_type md[4] = '{GPL_ZERO_DELAY, GPL_EXT_FEEDBACK, GPL_NORMAL, GPL_NORMAL};
      logic [7:0] m[4] = '{8'h04, 8'h04, 8'h04, 8'h03};
      logic [1:0] q[4] = '{2'h1, 2'h3, 2'h2, 2'h1};
      logic rj[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      int ne[4] = '{20, 20, 20, 15};
      for (int i = 0; i < 4; i++) begin
         start(m[i], 5'h02, q[i], md[i], 1'b0);
         wait_lock(1'b1, 3000);
         chk("shift refused", rj[i], rej);
         chk("step", rj[i] ? 6'h00 : 6'h02, trim.step);
         chk("step size", 10'd1000, trim.step_ps);
         chk("fine a", 5'h08, trim.fine[0]);
         chk("fine b", 5'h1c, trim.fine[1]);
         count(2000);
         near("ext in mode", ne[i], n[3]);
      end
   endtask

   // Reset for six cycles with the board clock running at 1 MHz.
   initial begin
      i_rst = 1'b1;
      en_pin = 1'b0;
      from_b = 1'b0;
      ref_run = 1'b1;
      half_ns = 16'd500;
      div = '{mul:8'h01, pre:5'h01, div_a:8'h01, div_b:8'h01, div_c:8'h01, div_ext:5'h01};
      shift = '0;
      mode = GPL_NORMAL;
      error_cnt = 0;
      checks_done = 0;
      cyc = 0;
      repeat (6) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(negedge i_core_clk);
      chk("reset outputs", 6'h00, {clk_a, clk_b, clk_c, clk_ext, lock, rej});
      t_lock;
      t_freq;
      t_from_b;
      t_off;
      t_ref;
      t_shift;
      end_sim;
   end
endmodule
`default_nettype wire
